// *** ccr_params.svh ***
// Purpose: Constants for the card configuration register bank.
// Assumes: Attribute byte addresses are 11 bits (A10..A0).
// Notes: Included by the package and the bank module.
//
// Summary of operation
// - Config registers at attribute 200h, even steps.
// - Attribute reads: CARD_INFO_STRUCTURE at A10:A9=00, regs at 01.
// - Common space byte lanes follow byte selects.
// - CARD_INFO_STRUCTURE writes, odd or high-only attribute accesses ignored.
// - Soft reset bit holds device reset, stays set.
// - Mode select resets to 00h, soft bit cleared.
// - Bit 6 chooses level or pulse interrupt.
// - Six-bit index selects memory or I/O mapping.
// - Changed flag drives status pin low when enabled in I/O mode.
// - Status change enable zero keeps pin high.
// - Byte I/O request stored, otherwise ignored.
// - Power-down bit change shows busy until reached.
// - Idle auto power saving, command wakes device.
// - Interrupt pending mirrors request, gated by enable.
// - Config/status resets 00h, fixed zero bits.
// - Ready change sets ready-changed bit.
// - Protect state fixed, protect-changed bit set by write only.
// - Ready bit reads ready, writes as mask.
// - Protect bit reads zero, writes as mask.
// - Masked write sets or clears changed bits.
// - Pin register resets 0Ch, fixed bits.
`ifndef CCR_PARAMS_SVH
`define CCR_PARAMS_SVH
`define CCR_MODE_SELECT_ADDR 11'h200
`define CCR_CONFIG_STATUS_ADDR 11'h202
`define CCR_PIN_STATE_ADDR 11'h204
`define CCR_MODE_SELECT_RESET 8'h00
`define CCR_CONFIG_STATUS_RESET 8'h00
`define CCR_PIN_STATE_RESET 8'h0c
`define CCR_SOFT_RESET_BIT 7
`define CCR_LEVEL_IRQ_BIT 6
`define CCR_STATUS_CHANGE_BIT 6
`define CCR_BYTE_IO_BIT 5
`define CCR_POWER_DOWN_BIT 2
`define CCR_IRQ_PENDING_BIT 1
`define CCR_READY_CHANGED_BIT 5
`define CCR_PROTECT_CHANGED_BIT 4
`define CCR_READY_STATE_BIT 1
`define CCR_PROTECT_STATE_BIT 0
`define CCR_IDX_MEMORY 6'h00
`define CCR_IDX_CONTIG_IO 6'h01
`define CCR_IDX_PRIMARY_IO 6'h02
`define CCR_IDX_SECONDARY_IO 6'h03
`define CCR_POWER_SWITCH_NS 200
`define CCR_POWER_SWITCH_CYC ((`CCR_POWER_SWITCH_NS + 24) / 25)
`define CCR_IDLE_SLEEP_CYC 16'h1000
`define CCR_PULSE_CYC 4'h4
`endif

// *** ccr_pkg.sv ***
`include "ccr_params.svh"
package ccr_pkg;
    typedef enum logic [1:0] {
        CCR_MAP_MEMORY,
        CCR_MAP_CONTIG_IO,
        CCR_MAP_PRIMARY_IO,
        CCR_MAP_SECONDARY_IO
    } ccr_map_t;
    typedef enum {
        CCR_PWR_ACTIVE,
        CCR_PWR_TO_SAVE,
        CCR_PWR_SAVE,
        CCR_PWR_TO_ACTIVE
    } ccr_pwr_t;
endpackage

// *** ccr_sync.sv ***
// Purpose: Two-stage synchroniser for a group of pin levels.
// Assumes: Inputs are asynchronous levels.
// Notes: Only the second stage is visible.
`timescale 1ns/1ps
module ccr_sync #(
    parameter int WIDTH = 8
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] async_in,
    input wire logic [WIDTH-1:0] reset_val,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1_reg;
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge core_clk) begin
                if (!nrst) begin
                    stage1_reg[i] <= reset_val[i];
                    sync_out[i] <= reset_val[i];
                end else begin
                    stage1_reg[i] <= async_in[i];
                    sync_out[i] <= stage1_reg[i];
                end
            end
        end
    endgenerate
endmodule

// *** ccr_card_config_bank.sv ***
// Purpose: Attribute-space decode and configuration register bank.
// Assumes: Host strobes are asynchronous and held for several clocks.
// Notes: Strobes act on their first synchronised active edge.
`timescale 1ns/1ps
`include "ccr_params.svh"
module ccr_card_config_bank (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic low_byte_select_n,
    input wire logic high_byte_select_n,
    input wire logic reg_select_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic [10:0] addr,
    input wire logic [15:0] data_in,
    input wire logic [7:0] cis_data,
    input wire logic [15:0] common_rd_data,
    input wire logic core_ready,
    input wire logic core_irq,
    input wire logic device_irq_enable_bit,
    input wire logic command_strobe,
    output logic [15:0] data_out,
    output logic [1:0] data_oe,
    output logic [10:0] cis_addr,
    output logic common_rd,
    output logic common_wr,
    output logic [1:0] common_lanes,
    output logic [15:0] common_wr_data,
    output logic core_reset,
    output logic power_save,
    output logic [1:0] map_mode,
    output logic io_mode,
    output logic status_changed_pin_n,
    output logic irq_pin_n
);
    import ccr_pkg::*;

    // ************************************************************
    // Pin synchronisation
    // ************************************************************
    // Selects, strobes, address and data all pass the same two flops,
    // so a strobe never reaches the decode ahead of its address.
    localparam int SYNC_W = 32;
    logic [SYNC_W-1:0] pins_async;
    logic [SYNC_W-1:0] pins_sync;
    logic [SYNC_W-1:0] pins_rst;
    assign pins_async = {low_byte_select_n, high_byte_select_n,
                         reg_select_n, read_strobe_n, write_strobe_n,
                         addr, data_in};
    assign pins_rst = {5'h1f, 27'h0000000};

    ccr_sync #(.WIDTH(SYNC_W)) u_sync (
        .core_clk(core_clk),
        .nrst(nrst),
        .async_in(pins_async),
        .reset_val(pins_rst),
        .sync_out(pins_sync)
    );

    logic lo_n, hi_n, reg_n, rd_n, wr_n;
    logic [10:0] a;
    logic [15:0] d;
    assign {lo_n, hi_n, reg_n, rd_n, wr_n, a, d} = pins_sync;

    // ************************************************************
    // Access decode
    // ************************************************************
    logic rd_d_reg, wr_d_reg;
    wire rd_act = !lo_n || !hi_n ? !rd_n : 1'b0;
    wire wr_act = !lo_n || !hi_n ? !wr_n : 1'b0;
    wire wr_start = wr_act && !wr_d_reg;
    wire rd_start = rd_act && !rd_d_reg;
    // Attribute accesses valid only via low select on even address.
    wire attr_ok = !reg_n && !lo_n && !a[0];
    wire attr_cis = attr_ok && (a[10:9] == 2'b00);
    wire attr_cfg = attr_ok && (a[10:9] == 2'b01);
    // Register words counted from the block base; only the low eight
    // word bits take part, the base itself comes from A10:A9.
    wire [7:0] cfg_word = a[8:1];
    wire [7:0] mode_word = 8'(`CCR_MODE_SELECT_ADDR >> 1);
    wire [7:0] stat_word = 8'(`CCR_CONFIG_STATUS_ADDR >> 1);
    wire [7:0] pin_word = 8'(`CCR_PIN_STATE_ADDR >> 1);
    wire sel_mode = attr_cfg && cfg_word == mode_word;
    wire sel_stat = attr_cfg && cfg_word == stat_word;
    wire sel_pin = attr_cfg && cfg_word == pin_word;
    // Common-space lanes: low alone, high alone, or word at even.
    wire [1:0] lanes = (!lo_n && !hi_n) ? (a[0] ? 2'b00 : 2'b11) :
                       !lo_n ? 2'b01 : !hi_n ? 2'b10 : 2'b00;
    wire common_acc = reg_n && lanes != 2'b00;

    // ************************************************************
    // Registers
    // ************************************************************
    logic [7:0] mode_select_reg, mode_select_next;
    logic status_change_enable_reg, byte_io_request_reg;
    logic power_down_request_reg;
    logic ready_changed_reg, protect_changed_reg;
    logic ready_state_reg;
    wire soft_reset_bit = mode_select_reg[`CCR_SOFT_RESET_BIT];
    wire level_irq_select = mode_select_reg[`CCR_LEVEL_IRQ_BIT];
    wire [5:0] config_index = mode_select_reg[5:0];
    wire in_io = config_index != `CCR_IDX_MEMORY;
    wire dev_rst = !nrst || soft_reset_bit;

    always_comb begin
        mode_select_next = mode_select_reg;
        if (wr_start && sel_mode) begin
            mode_select_next = d[7:0];
        end
    end

    // Soft reset leaves its own bit alone so software can release it.
    // Meanwhile every other field sits at its reset value, and a host
    // write can only drop the bit, which leaves the card unconfigured.
    wire [7:0] mode_held = (wr_start && sel_mode) ?
                           {d[7], 7'h00} : 8'h80;

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            mode_select_reg <= `CCR_MODE_SELECT_RESET;
        end else if (soft_reset_bit) begin
            mode_select_reg <= mode_held;
        end else begin
            mode_select_reg <= mode_select_next;
        end
    end

    // ************************************************************
    // Power state
    // ************************************************************
    ccr_pwr_t pwr_reg;
    logic [15:0] idle_cnt_reg;
    logic [7:0] pwr_cnt_reg;
    logic auto_save_reg;
    wire want_save = power_down_request_reg || auto_save_reg;
    wire pwr_busy = pwr_reg == CCR_PWR_TO_SAVE ||
                    pwr_reg == CCR_PWR_TO_ACTIVE;

    // Only a command or a reset counts as activity; register traffic
    // from the host does not hold off the automatic power saving.
    always_ff @(posedge core_clk) begin
        if (dev_rst || command_strobe) begin
            idle_cnt_reg <= 16'h0000;
            auto_save_reg <= 1'b0;
        end else if (idle_cnt_reg == `CCR_IDLE_SLEEP_CYC - 16'h0001) begin
            auto_save_reg <= 1'b1;
        end else begin
            idle_cnt_reg <= idle_cnt_reg + 16'h0001;
        end
    end

    always_ff @(posedge core_clk) begin
        if (dev_rst) begin
            pwr_reg <= CCR_PWR_ACTIVE;
            pwr_cnt_reg <= 8'h00;
        end else begin
            unique case (pwr_reg)
                CCR_PWR_ACTIVE: begin
                    pwr_cnt_reg <= 8'h00;
                    if (want_save) begin
                        pwr_reg <= CCR_PWR_TO_SAVE;
                    end
                end
                CCR_PWR_SAVE: begin
                    pwr_cnt_reg <= 8'h00;
                    if (!want_save) begin
                        pwr_reg <= CCR_PWR_TO_ACTIVE;
                    end
                end
                // A request that flips mid-switch waits for this one to end.
                CCR_PWR_TO_SAVE, CCR_PWR_TO_ACTIVE: begin
                    if (pwr_cnt_reg == 8'(`CCR_POWER_SWITCH_CYC - 1)) begin
                        pwr_cnt_reg <= 8'h00;
                        pwr_reg <= pwr_reg == CCR_PWR_TO_SAVE ?
                                   CCR_PWR_SAVE : CCR_PWR_ACTIVE;
                    end else begin
                        pwr_cnt_reg <= pwr_cnt_reg + 8'h01;
                    end
                end
            endcase
        end
    end

    // ************************************************************
    // Status and pin replacement
    // ************************************************************
    // Ready reads busy for the whole switch time in both directions,
    // so a power switch with core_ready high also raises the ready-changed flag.
    wire ready_now = core_ready && !pwr_busy;
    wire ready_edge = ready_now != ready_state_reg;
    wire irq_req = core_irq && device_irq_enable_bit;
    wire changed = ready_changed_reg || protect_changed_reg;
    wire pin_wr = wr_start && sel_pin;

    always_ff @(posedge core_clk) begin
        if (dev_rst) begin
            status_change_enable_reg <= 1'b0;
            byte_io_request_reg <= 1'b0;
            power_down_request_reg <= 1'b0;
            ready_state_reg <= 1'b0;
            ready_changed_reg <= 1'b0;
            protect_changed_reg <= 1'b0;
        end else begin
            ready_state_reg <= ready_now;
            if (wr_start && sel_stat) begin
                status_change_enable_reg <= d[`CCR_STATUS_CHANGE_BIT];
                byte_io_request_reg <= d[`CCR_BYTE_IO_BIT];
                power_down_request_reg <= d[`CCR_POWER_DOWN_BIT];
            end
            // Hardware set wins over a masked host clear.
            if (ready_edge) begin
                ready_changed_reg <= 1'b1;
            end else if (pin_wr && d[`CCR_READY_STATE_BIT]) begin
                ready_changed_reg <= d[`CCR_READY_CHANGED_BIT];
            end
            if (pin_wr && d[`CCR_PROTECT_STATE_BIT]) begin
                protect_changed_reg <= d[`CCR_PROTECT_CHANGED_BIT];
            end
            // Protect state is fixed, so no hardware set ever occurs.
        end
    end

    wire [7:0] stat_rd = {changed, status_change_enable_reg,
                          byte_io_request_reg, 2'b00,
                          power_down_request_reg, irq_req,
                          1'b0};
    wire [7:0] pin_rd = {2'b00, ready_changed_reg, protect_changed_reg,
                         2'b11, ready_state_reg, 1'b0};
    // Offsets in the block with no register behind them read as zero.
    wire [7:0] cfg_rd = sel_mode ? mode_select_reg : sel_stat ? stat_rd :
                        sel_pin ? pin_rd : 8'h00;

    // ************************************************************
    // Interrupt and status pins
    // ************************************************************
    // A pulse starts only on a rising request, so a request held high
    // gives one pulse of fixed width and no more.
    logic [3:0] pulse_cnt_reg;
    logic irq_d_reg;
    always_ff @(posedge core_clk) begin
        if (dev_rst) begin
            pulse_cnt_reg <= 4'h0;
            irq_d_reg <= 1'b0;
            irq_pin_n <= 1'b1;
            status_changed_pin_n <= 1'b1;
        end else begin
            irq_d_reg <= irq_req;
            if (irq_req && !irq_d_reg) begin
                pulse_cnt_reg <= `CCR_PULSE_CYC;
            end else if (pulse_cnt_reg != 4'h0) begin
                pulse_cnt_reg <= pulse_cnt_reg - 4'h1;
            end
            irq_pin_n <= !(in_io && (level_irq_select ? irq_req :
                           pulse_cnt_reg != 4'h0));
            status_changed_pin_n <= !(in_io && status_change_enable_reg &&
                                      changed);
        end
    end

    // ************************************************************
    // Host data path
    // ************************************************************
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            rd_d_reg <= 1'b0;
            wr_d_reg <= 1'b0;
            data_out <= 16'h0000;
            data_oe <= 2'b00;
            cis_addr <= 11'h000;
            common_rd <= 1'b0;
            common_wr <= 1'b0;
            common_lanes <= 2'b00;
            common_wr_data <= 16'h0000;
            core_reset <= 1'b1;
            power_save <= 1'b0;
            map_mode <= 2'b00;
            io_mode <= 1'b0;
        end else begin
            rd_d_reg <= rd_act;
            wr_d_reg <= wr_act;
            cis_addr <= a;
            common_rd <= rd_start && common_acc;
            common_wr <= wr_start && common_acc;
            common_lanes <= lanes;
            common_wr_data <= d;
            core_reset <= soft_reset_bit;
            power_save <= pwr_reg == CCR_PWR_SAVE;
            map_mode <= config_index[1:0];
            io_mode <= in_io;
            if (rd_act && (attr_cis || attr_cfg)) begin
                data_out <= {8'h00, attr_cis ? cis_data : cfg_rd};
                data_oe <= 2'b01;
            end else if (rd_act && common_acc) begin
                data_out <= common_rd_data;
                data_oe <= lanes;
            end else begin
                // Idle and refused reads return zero, never the last byte.
                data_out <= 16'h0000;
                data_oe <= 2'b00;
            end
        end
    end
endmodule

// *** ccr_bank_chk.sv ***
// Purpose: Port-level assertions for the configuration register bank.
// Assumes: One clock domain; reset is nrst, synchronous, active low.
// Notes: Bound to every instance of the bank.
`timescale 1ns/1ps
module ccr_bank_chk (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic low_byte_select_n,
    input wire logic reg_select_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic [1:0] data_oe,
    input wire logic common_rd,
    input wire logic common_wr,
    input wire logic [1:0] common_lanes,
    input wire logic [1:0] map_mode,
    input wire logic io_mode,
    input wire logic status_changed_pin_n
);
    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    a_index_io: assert property (map_mode != 2'b00 |-> io_mode)
        else $error("io mode low with a nonzero map");
    a_status_changed_pin_memory: assert property (
        $past(!io_mode) && !io_mode |-> status_changed_pin_n)
        else $error("status pin low in memory mode");
    a_oe_idle: assert property (
        read_strobe_n [*4] |-> data_oe == 2'b00)
        else $error("data lanes driven without read strobe");
    a_common_wr_seen: assert property (
        $fell(write_strobe_n) && reg_select_n && !low_byte_select_n
        |-> ##[1:6] common_wr)
        else $error("common write never issued");
    a_attr_quiet: assert property (
        !reg_select_n [*6] |-> !common_wr && !common_rd)
        else $error("common access during attribute cycle");
    a_wr_pulse: assert property (common_wr |=> !common_wr)
        else $error("common write longer than one cycle");
    a_wr_lanes: assert property (
        common_wr |-> common_lanes != 2'b00)
        else $error("common write with no lane");
    a_rd_wr_excl: assert property (!(common_rd && common_wr))
        else $error("common read and write together");
endmodule
bind ccr_card_config_bank ccr_bank_chk chk_i (.core_clk, .nrst,
    .low_byte_select_n, .reg_select_n, .read_strobe_n, .write_strobe_n,
    .data_oe, .common_rd, .common_wr, .common_lanes, .map_mode, .io_mode,
    .status_changed_pin_n);

// *** ccr_host_model.sv ***
// Purpose: Host bus controller model driving the card's strobes.
// Assumes: Signals change on falling edges and hold for six cycles.
// Notes: Released address and data lines show the inverse of their last value.
`timescale 1ns/1ps
module ccr_host_model (
    input wire logic core_clk,
    input wire logic [10:0] cis_addr,
    input wire logic [15:0] data_out,
    input wire logic [1:0] data_oe,
    output logic low_byte_select_n,
    output logic high_byte_select_n,
    output logic reg_select_n,
    output logic read_strobe_n,
    output logic write_strobe_n,
    output logic [10:0] addr,
    output logic [15:0] data_in,
    output logic [7:0] cis_data,
    output logic [15:0] common_rd_data
);
    assign cis_data = cis_addr[7:0] ^ 8'h5a;
    assign common_rd_data = {addr[7:0] ^ 8'hc3, 5'h00, addr[10:8]};
    initial begin
        {low_byte_select_n, high_byte_select_n, reg_select_n} = 3'b111;
        {read_strobe_n, write_strobe_n} = 2'b11;
        addr = 11'h000;
        data_in = 16'h0000;
    end
    task automatic acc(input logic w, input logic r, input logic [1:0] ln,
        input logic [10:0] a, input logic [15:0] d, output logic [17:0] q);
        @(negedge core_clk);
        {high_byte_select_n, low_byte_select_n} = ~ln;
        reg_select_n = ~r;
        addr = a;
        data_in = d;
        read_strobe_n = w;
        write_strobe_n = ~w;
        repeat (6) @(posedge core_clk);
        q = {data_oe, data_out};
        @(negedge core_clk);
        // Strobes rise between accesses so each one is seen anew.
        {read_strobe_n, write_strobe_n} = 2'b11;
        {low_byte_select_n, high_byte_select_n} = 2'b11;
        addr = ~a;
        data_in = ~d;
        repeat (4) @(negedge core_clk);
    endtask
endmodule

// *** tb.sv ***
// Purpose: Self-checking bench for the configuration register bank.
// Assumes: Host model drives on falling edges; bench drives core_ready.
// Notes: Expected values come from a small model kept in the bench.
`timescale 1ns/1ps
module tb;
    import ccr_pkg::*;
    // ****************************************
    // Signals and model state
    // ****************************************
    logic core_clk = 0;
    logic nrst = 0;
    logic core_irq = 0;
    logic irq_en = 0;
    logic cmd = 0;
    logic core_ready = 1;
    wire low_byte_select_n, high_byte_select_n, reg_select_n;
    wire read_strobe_n, write_strobe_n, common_rd, common_wr, core_reset;
    wire power_save, io_mode, status_changed_pin_n, irq_pin_n;
    wire [10:0] addr, cis_addr;
    wire [15:0] data_in, data_out, common_rd_data, common_wr_data;
    wire [7:0] cis_data;
    wire [1:0] data_oe, common_lanes, map_mode;
    logic [7:0] mode, cfg, d;
    logic rc, pc, rdy;
    logic [17:0] q;
    logic [15:0] w, m;
    logic [10:0] a;
    logic [31:0] seed = 32'hd9ada2ee;
    int miscompares = 0;
    int checks = 0;
    int i;
    always #12.5 core_clk = ~core_clk;
    ccr_card_config_bank dut (.core_clk, .nrst, .low_byte_select_n,
        .high_byte_select_n, .reg_select_n, .read_strobe_n,
        .write_strobe_n, .addr, .data_in, .cis_data, .common_rd_data,
        .core_ready, .core_irq, .device_irq_enable_bit(irq_en),
        .command_strobe(cmd), .data_out, .data_oe, .cis_addr, .common_rd,
        .common_wr, .common_lanes, .common_wr_data, .core_reset,
        .power_save, .map_mode, .io_mode, .status_changed_pin_n,
        .irq_pin_n);
    ccr_host_model host (.core_clk, .cis_addr, .data_out, .data_oe,
        .low_byte_select_n, .high_byte_select_n, .reg_select_n,
        .read_strobe_n, .write_strobe_n, .addr, .data_in, .cis_data,
        .common_rd_data);
    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [7:0] cexp();
        return {rc | pc, cfg[6:2], core_irq & irq_en, 1'b0};
    endfunction
    function automatic logic [7:0] pexp();
        return {2'b00, rc, pc, 2'b11, rdy, 1'b0};
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask
    task automatic wr(input logic [10:0] ad, input logic [7:0] v);
        host.acc(1'b1, 1'b1, 2'b01, ad, {8'h00, v}, q);
    endtask
    task automatic rd(input logic [10:0] ad, input logic [7:0] e);
        host.acc(1'b0, 1'b1, 2'b01, ad, 16'h0000, q);
        chk({8'h00, q[7:0]}, {8'h00, e});
        chk({14'h0, q[17:16]}, 16'h0001);
    endtask
    task automatic close_out();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    always @(posedge core_clk) begin
        if (common_wr === 1'b1) begin
            chk(common_wr_data & m, w & m);
        end
        if (common_rd === 1'b1 || common_wr === 1'b1) begin
            chk({14'h0, common_lanes}, {14'h0, m[8], m[0]});
        end
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        miscompares++;
        close_out();
    end
    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        {mode, cfg, rc, pc} = 18'h0;
        repeat (10) @(negedge core_clk);
        nrst = 1;
        // Leaving reset, ready rises from its reset value of zero.
        {rc, rdy} = 2'b11;
        rd(11'h200, 8'h00);
        rd(11'h202, cexp());
        rd(11'h204, pexp());
        for (i = 0; i < 4; i++) begin
            mode = {1'b0, 1'(xs()), 6'(i)};
            wr(11'h200, mode);
            rd(11'h200, mode);
            chk({14'h0, map_mode}, 16'(i));
            chk({15'h0, io_mode}, {15'h0, i != 0});
        end
        d = 8'(xs()) & 8'hfb;
        cfg = d & 8'h60;
        wr(11'h202, d);
        rd(11'h202, cexp());
        // Writes outside the registers must be ignored.
        wr(11'h201, 8'hff);
        host.acc(1'b1, 1'b1, 2'b10, 11'h200, 16'hffff, q);
        wr(11'h000, 8'h11);
        rd(11'h200, mode);
        rd(11'h000, 8'h5a);
        host.acc(1'b0, 1'b1, 2'b01, 11'h201, 16'h0000, q);
        chk({8'h00, q[7:0]}, 16'h0000);
        chk({14'h0, q[17:16]}, 16'h0000);
        wr(11'h202, 8'h44);
        cfg = 8'h44;
        rc = 1'b1;
        repeat (20) @(negedge core_clk);
        chk({15'h0, power_save}, 16'h0001);
        chk({15'h0, status_changed_pin_n}, 16'h0000);
        rd(11'h204, pexp());
        wr(11'h202, 8'h00);
        cfg = 8'h00;
        repeat (20) @(negedge core_clk);
        chk({15'h0, power_save}, 16'h0000);
        chk({15'h0, status_changed_pin_n}, 16'h0001);
        rd(11'h202, cexp());
        for (i = 0; i < 6; i++) begin
            d = 8'(xs());
            rc = d[1] ? d[5] : rc;
            pc = d[0] ? d[4] : pc;
            wr(11'h204, d);
            rd(11'h204, pexp());
        end
        core_ready = 1'b0;
        {rc, rdy} = 2'b10;
        rd(11'h204, pexp());
        core_ready = 1'b1;
        rdy = 1'b1;
        core_irq = 1'b1;
        irq_en = 1'b1;
        rd(11'h202, cexp());
        chk({15'h0, irq_pin_n}, {15'h0, ~mode[6]});
        irq_en = 1'b0;
        rd(11'h202, cexp());
        core_irq = 1'b0;
        for (i = 1; i < 4; i++) begin
            a = 11'(xs()) & 11'h7fe;
            m = {{8{i[1]}}, {8{i[0]}}};
            host.acc(1'b0, 1'b0, 2'(i), a, 16'h0000, q);
            chk({14'h0, q[17:16]}, 16'(i));
            chk(q[15:0] & m, {a[7:0] ^ 8'hc3, 5'h00, a[10:8]} & m);
            w = 16'(xs());
            host.acc(1'b1, 1'b0, 2'(i), a, w, q);
        end
        wr(11'h200, 8'h80);
        {cfg, rc, pc, rdy} = 11'h0;
        chk({15'h0, core_reset}, 16'h0001);
        rd(11'h200, 8'h80);
        rd(11'h204, pexp());
        wr(11'h200, 8'h00);
        {rc, rdy} = 2'b11;
        chk({14'h0, core_reset, io_mode}, 16'h0000);
        repeat (4200) @(negedge core_clk);
        chk({15'h0, power_save}, 16'h0001);
        cmd = 1'b1;
        @(negedge core_clk);
        cmd = 1'b0;
        repeat (20) @(negedge core_clk);
        chk({15'h0, power_save}, 16'h0000);
        close_out();
    end
endmodule
